// File: core/ncd_core.sv
// Execution logic of a 4-bit core for transfer, RAM addressing, arithmetic,
// bit and compare instructions, including the skip mechanism.
// Assumes: instructions arrive one per cycle with instr_valid_i; RAM nibble at
// the current pointer is read combinationally on ram_rdata_i; ROM lookup data
// is returned on rom_data_i in the cycle after rom_req_o.
//
// How it works
// - Swap-dec: swap acc/RAM, file^=j, digit--, skip when digit becomes 15.
// - Swap-inc: swap acc/RAM, file^=j, digit++, skip when digit becomes 0.
// - Digit increment 0x013: add one, skip next only when new value is 0.
// - Digit decrement 0x017: subtract one, skip next only when new value 15.
// - Load from RAM into acc, then file select ^= immediate j.
// - Plain swap acc with RAM, file ^= j; digit and skip untouched.
// - Store acc into RAM at pointer, then file select ^= j.
// - Copies aux->acc, acc->aux, digit->acc, acc->digit; no carry, no skip.
// - Write wide register: aux to bits 7..4, acc to bits 3..0.
// - Read wide register: upper nibble to aux, lower nibble to acc.
// - Copy low three acc bits into ROM-address-low; acc bit 3 ignored.
// - Read ROM-address-low into acc bits 2..0, acc bit 3 cleared.
// - Read bank select into acc bits 1..0, acc bits 3..2 cleared.
// - Copy full file select register into acc, no carry or skip change.
// - Read stack depth into acc bits 2..0, acc bit 3 cleared.
// - Pointer load sets file and digit; consecutive ones after first skipped.
// - Bank load writes 2-bit immediate into bank select.
// - Add with carry: acc+RAM+carry to acc, carry out to carry flag.
// - Add immediate: acc plus 4-bit immediate kept in acc.
// - Bit set and bit clear force RAM bit j of addressed nibble.
// - Bit test skips next instruction when RAM bit j reads zero.
// - Acc immediate load; in a run only the first takes effect.
// - ROM lookup: bits 9..8 to ROM-addr-low, 7..4 aux, 3..0 acc.
// - Add immediate keeps carry; skips next when no overflow.
// - Plain add memory adds RAM into acc, carry untouched.
module ncd_core
   import ncd_pkg::*;
#(
   parameter int STACK_W = 3
) (
   // Clock, reset, enable
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   input  wire logic             clk_en_i,
   // Instruction stream
   input  wire logic             instr_valid_i,
   input  wire logic [NCD_IW-1:0] instr_i,
   output logic                  busy_o,
   // Data RAM at the current pointer
   input  wire logic [3:0]       ram_rdata_i,
   output logic                  ram_we_o,
   output logic      [3:0]       ram_wdata_o,
   output logic      [1:0]       bank_sel_o,
   output logic      [3:0]       file_sel_o,
   output logic      [3:0]       digit_sel_o,
   // ROM table lookup
   output logic                  rom_req_o,
   output logic      [5:0]       rom_page_o,
   output logic      [6:0]       rom_addr_o,
   input  wire logic [NCD_IW-1:0] rom_data_i,
   // Stack depth from the branch unit
   input  wire logic [STACK_W-1:0] stack_depth_i,
   // Architectural state
   output logic      [3:0]       acc_o,
   output logic      [3:0]       aux_o,
   output logic      [7:0]       wide_o,
   output logic      [2:0]       rom_addr_low_o,
   output logic                  carry_flag_o,
   output logic                  skip_pending_o
);

   // ==========================================================================
   // Elaboration check
   if (STACK_W != 3) begin : g_bad_stack
      $error("ncd_core serves a three-bit stack depth only");
   end

   // ==========================================================================
   // State
   ncd_arch_t    st_reg;
   ncd_arch_t    st_next;
   logic         skip_reg;
   logic         skip_next;
   ncd_run_t     run_reg;
   ncd_run_t     run_next;
   logic         lookup_reg;
   ncd_ram_req_t ram_req;
   logic         lookup_start;
   logic         do_exec;

   // ==========================================================================
   // Adder shared by the add instructions
   logic [3:0] add_b;
   logic       add_cin;
   logic [3:0] add_sum;
   logic       add_cout;

   ncd_alu #(
      .W (NCD_DW)
   ) u_alu (
      .a_i    (st_reg.acc),
      .b_i    (add_b),
      .cin_i  (add_cin),
      .sum_o  (add_sum),
      .cout_o (add_cout)
   );

   // Immediate fields
   logic [3:0] imm4;
   logic [1:0] imm2;
   logic [3:0] digit_inc;
   logic [3:0] digit_dec;
   assign imm4      = instr_i[3:0];
   assign imm2      = instr_i[1:0];
   assign digit_inc = st_reg.digit_sel + 4'h1;
   assign digit_dec = st_reg.digit_sel - 4'h1;

   // Lookup takes a second cycle for the ROM word; the stream must wait
   assign busy_o  = lookup_reg;
   assign do_exec = instr_valid_i && !lookup_reg;

   // ==========================================================================
   // Decode and execute
   always_comb begin
      st_next       = st_reg;
      skip_next     = skip_reg;
      run_next      = run_reg;
      ram_req.we    = 1'b0;
      ram_req.wdata = st_reg.acc;
      add_b         = ram_rdata_i;
      add_cin       = 1'b0;
      lookup_start  = 1'b0;
      if (do_exec) begin
         skip_next = 1'b0;
         run_next  = NCD_RUN_NONE;
         if (skip_reg) begin
         end else if ((run_reg == NCD_RUN_PTR && instr_i[9:8] == PFX_LOAD_POINTER) ||
                      (run_reg == NCD_RUN_ACC && instr_i[9:4] == PFX_ACC_IMM_LOAD)) begin
            // later words of a run do nothing
            // Only the same kind is dropped; any other word ends the run and executes.
            run_next = run_reg;
         end else if (instr_i[9:8] == PFX_LOAD_POINTER) begin
            st_next.file_sel  = instr_i[7:4];
            st_next.digit_sel = instr_i[3:0];
            run_next          = NCD_RUN_PTR;
         end else if (instr_i[9:4] == PFX_ACC_IMM_LOAD) begin
            st_next.acc = imm4;
            run_next    = NCD_RUN_ACC;
         end else if (instr_i[9:4] == PFX_LOAD_ACC_RAM) begin
            st_next.acc      = ram_rdata_i;
            st_next.file_sel = st_reg.file_sel ^ imm4;
         end else if (instr_i[9:4] == PFX_SWAP_ACC_RAM ||
                      instr_i[9:4] == PFX_SWAP_DEC ||
                      instr_i[9:4] == PFX_SWAP_INC) begin
            st_next.acc      = ram_rdata_i;
            ram_req.we       = 1'b1;
            st_next.file_sel = st_reg.file_sel ^ imm4;
            if (instr_i[9:4] == PFX_SWAP_DEC) begin
               st_next.digit_sel = digit_dec;
               skip_next         = (digit_dec == NCD_DIGIT_MAX);
            end else if (instr_i[9:4] == PFX_SWAP_INC) begin
               st_next.digit_sel = digit_inc;
               skip_next         = (digit_inc == NCD_DIGIT_ZERO);
            end
         end else if (instr_i[9:4] == PFX_STORE_ACC_RAM) begin
            ram_req.we       = 1'b1;
            st_next.file_sel = st_reg.file_sel ^ imm4;
         end else if (instr_i[9:4] == PFX_ADD_IMM) begin
            add_b       = imm4;
            st_next.acc = add_sum;
            skip_next   = !add_cout;
         end else if (instr_i[9:6] == PFX_ROM_LOOKUP) begin
            lookup_start = 1'b1;
         end else if (instr_i[9:2] == PFX_LOAD_BANK) begin
            st_next.bank_sel = imm2;
         end else if (instr_i[9:2] == PFX_SET_BIT || instr_i[9:2] == PFX_CLEAR_BIT) begin
            ram_req.we    = 1'b1;
            ram_req.wdata = ram_rdata_i;
            ram_req.wdata[imm2] = (instr_i[9:2] == PFX_SET_BIT);
         end else if (instr_i[9:2] == PFX_SKIP_BIT_ZERO) begin
            skip_next = !ram_rdata_i[imm2];
         end else begin
            case (instr_i)
               OP_COPY_AUX_TO_ACC: st_next.acc       = st_reg.aux;
               OP_COPY_ACC_TO_AUX: st_next.aux       = st_reg.acc;
               OP_COPY_DIGIT_ACC:  st_next.acc       = st_reg.digit_sel;
               OP_COPY_ACC_DIGIT:  st_next.digit_sel = st_reg.acc;
               OP_WRITE_WIDE:      st_next.wide      = {st_reg.aux, st_reg.acc};
               OP_READ_WIDE: begin
                  st_next.aux = st_reg.wide[7:4];
                  st_next.acc = st_reg.wide[3:0];
               end
               OP_WRITE_RAL:       st_next.rom_addr_low = st_reg.acc[2:0];
               OP_READ_RAL:        st_next.acc = {1'b0, st_reg.rom_addr_low};
               OP_READ_BANK:       st_next.acc = {2'b00, st_reg.bank_sel};
               OP_READ_FILE:       st_next.acc = st_reg.file_sel;
               OP_READ_STACK:      st_next.acc = {1'b0, stack_depth_i};
               OP_DIGIT_INC: begin
                  st_next.digit_sel = digit_inc;
                  skip_next         = (digit_inc == NCD_DIGIT_ZERO);
               end
               OP_DIGIT_DEC: begin
                  st_next.digit_sel = digit_dec;
                  skip_next         = (digit_dec == NCD_DIGIT_MAX);
               end
               OP_ADD_RAM:         st_next.acc = add_sum;
               OP_ADD_RAM_CARRY: begin
                  add_cin       = st_reg.carry;
                  st_next.acc   = add_sum;
                  st_next.carry = add_cout;
               end
               OP_AND_RAM:         st_next.acc = st_reg.acc & ram_rdata_i;
               OP_OR_RAM:          st_next.acc = st_reg.acc | ram_rdata_i;
               OP_COMPLEMENT:      st_next.acc = ~st_reg.acc;
               OP_SET_CARRY:       st_next.carry = 1'b1;
               OP_CLEAR_CARRY:     st_next.carry = 1'b0;
               OP_SKIP_CARRY_ZERO: skip_next = !st_reg.carry;
               OP_ROTATE_RIGHT: begin
                  st_next.acc   = {st_reg.carry, st_reg.acc[3:1]};
                  st_next.carry = st_reg.acc[0];
               end
               OP_SKIP_ACC_EQ_RAM: skip_next = (st_reg.acc == ram_rdata_i);
               default: ;
            endcase
         end
      end else if (lookup_reg) begin
         // ROM word split; top ROM-addr-low bit cleared
         st_next.rom_addr_low = {1'b0, rom_data_i[9:8]};
         st_next.aux          = rom_data_i[7:4];
         st_next.acc          = rom_data_i[3:0];
      end
   end

   // ==========================================================================
   // Architectural registers
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= '{acc: NCD_NIB_RST, aux: NCD_NIB_RST, file_sel: NCD_NIB_RST,
                     digit_sel: NCD_NIB_RST, bank_sel: 2'h0, rom_addr_low: 3'h0,
                     wide: NCD_WIDE_RST, carry: 1'b0};
      end else if (clk_en_i) begin
         st_reg <= st_next;
      end
   end

   // Skip state and run tracking
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         skip_reg <= 1'b0;
         run_reg  <= NCD_RUN_NONE;
      end else if (clk_en_i) begin
         skip_reg <= skip_next;
         run_reg  <= run_next;
      end
   end

   // Lookup second cycle flag; one extra cycle is the price of a registered ROM
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lookup_reg <= 1'b0;
      end else if (clk_en_i) begin
         lookup_reg <= lookup_start;
      end
   end

   // ==========================================================================
   // Outputs
   assign ram_we_o       = ram_req.we && clk_en_i;
   assign ram_wdata_o    = ram_req.wdata;
   assign rom_req_o      = lookup_start && clk_en_i;
   assign rom_page_o     = instr_i[5:0];
   assign rom_addr_o     = {st_reg.rom_addr_low, st_reg.acc};
   assign bank_sel_o     = st_reg.bank_sel;
   assign file_sel_o     = st_reg.file_sel;
   assign digit_sel_o    = st_reg.digit_sel;
   assign acc_o          = st_reg.acc;
   assign aux_o          = st_reg.aux;
   assign wide_o         = st_reg.wide;
   assign rom_addr_low_o = st_reg.rom_addr_low;
   assign carry_flag_o   = st_reg.carry;
   assign skip_pending_o = skip_reg;

endmodule

// File: core/ncd_pkg.sv
// Package for the nibble core data-move decoder: opcodes, field layout, widths.
// Assumes one core clock; RAM and ROM are reached through plain ports of the top.
package ncd_pkg;

   // ==========================================================================
   // Widths
   localparam int NCD_IW   = 10;
   localparam int NCD_DW   = 4;

   // ==========================================================================
   // Fixed opcodes
   localparam logic [9:0] OP_COPY_AUX_TO_ACC  = 10'h01e;
   localparam logic [9:0] OP_COPY_ACC_TO_AUX  = 10'h00e;
   localparam logic [9:0] OP_COPY_DIGIT_ACC   = 10'h01f;
   localparam logic [9:0] OP_COPY_ACC_DIGIT   = 10'h00c;
   localparam logic [9:0] OP_WRITE_WIDE       = 10'h01a;
   localparam logic [9:0] OP_READ_WIDE        = 10'h02a;
   localparam logic [9:0] OP_WRITE_RAL        = 10'h029;
   localparam logic [9:0] OP_READ_RAL         = 10'h051;
   localparam logic [9:0] OP_READ_BANK        = 10'h053;
   localparam logic [9:0] OP_READ_FILE        = 10'h052;
   localparam logic [9:0] OP_READ_STACK       = 10'h050;
   localparam logic [9:0] OP_DIGIT_INC        = 10'h013;
   localparam logic [9:0] OP_DIGIT_DEC        = 10'h017;
   localparam logic [9:0] OP_ADD_RAM          = 10'h00a;
   localparam logic [9:0] OP_ADD_RAM_CARRY    = 10'h00b;
   localparam logic [9:0] OP_AND_RAM          = 10'h018;
   localparam logic [9:0] OP_OR_RAM           = 10'h019;
   localparam logic [9:0] OP_COMPLEMENT       = 10'h01c;
   localparam logic [9:0] OP_SET_CARRY        = 10'h007;
   localparam logic [9:0] OP_CLEAR_CARRY      = 10'h006;
   localparam logic [9:0] OP_SKIP_CARRY_ZERO  = 10'h02f;
   localparam logic [9:0] OP_ROTATE_RIGHT     = 10'h01d;
   localparam logic [9:0] OP_SKIP_ACC_EQ_RAM  = 10'h026;

   // ==========================================================================
   // Opcode prefixes (top bits) for instructions with immediates
   localparam logic [5:0] PFX_LOAD_ACC_RAM   = 6'h2c;  // 10'h2cj
   localparam logic [5:0] PFX_SWAP_ACC_RAM   = 6'h2d;  // 10'h2dj
   localparam logic [5:0] PFX_SWAP_DEC       = 6'h2f;  // 10'h2fj
   localparam logic [5:0] PFX_SWAP_INC       = 6'h2e;  // 10'h2ej
   localparam logic [5:0] PFX_STORE_ACC_RAM  = 6'h2b;  // 10'h2bj
   localparam logic [5:0] PFX_ACC_IMM_LOAD   = 6'h07;  // 10'h07n
   localparam logic [5:0] PFX_ADD_IMM        = 6'h06;  // 10'h06n
   localparam logic [1:0] PFX_LOAD_POINTER   = 2'h3;   // 10'h3xy
   localparam logic [7:0] PFX_LOAD_BANK      = 8'h12;  // 10'h048+z
   localparam logic [7:0] PFX_SET_BIT        = 8'h17;  // 10'h05c+j
   localparam logic [7:0] PFX_CLEAR_BIT      = 8'h13;  // 10'h04c+j
   localparam logic [7:0] PFX_SKIP_BIT_ZERO  = 8'h08;  // 10'h020+j
   localparam logic [3:0] PFX_ROM_LOOKUP     = 4'h2;   // 10'h080+p
   localparam logic [4:0] PFX_SKIP_ACC_EQ_N  = 5'h01;  // 10'h025, then 10'h07n

   // ==========================================================================
   // Reset values and wrap points
   localparam logic [3:0] NCD_NIB_RST     = 4'h0;
   localparam logic [7:0] NCD_WIDE_RST    = 8'h00;
   localparam logic [3:0] NCD_DIGIT_MAX   = 4'hf;
   localparam logic [3:0] NCD_DIGIT_ZERO  = 4'h0;

   // Run kind used by the "first of a run executes" mechanism
   typedef enum logic [1:0] {
      NCD_RUN_NONE = 2'b00,
      NCD_RUN_ACC  = 2'b01,
      NCD_RUN_PTR  = 2'b11
   } ncd_run_t;

   // Architectural register bundle
   typedef struct packed {
      logic [3:0] acc;
      logic [3:0] aux;
      logic [3:0] file_sel;
      logic [3:0] digit_sel;
      logic [1:0] bank_sel;
      logic [2:0] rom_addr_low;
      logic [7:0] wide;
      logic       carry;
   } ncd_arch_t;

   // Data RAM request
   typedef struct packed {
      logic       we;
      logic [3:0] wdata;
   } ncd_ram_req_t;

endpackage

// File: core/ncd_alu.sv
// Four-bit adder for the nibble core decoder.
// Assumes purely combinational use by the decoder on the same clock.
module ncd_alu
   import ncd_pkg::*;
#(
   parameter int W = NCD_DW
) (
   // Operands
   input  wire logic [W-1:0] a_i,
   input  wire logic [W-1:0] b_i,
   input  wire logic         cin_i,
   // Result
   output logic      [W-1:0] sum_o,
   output logic              cout_o
);

   // ==========================================================================
   // Elaboration check
   if (W < 1) begin : g_bad_width
      $error("ncd_alu width must be at least one");
   end

   // ==========================================================================
   // Adder, carry taken from the extra top bit
   logic [W:0] full;
   assign full   = {1'b0, a_i} + {1'b0, b_i} + {{W{1'b0}}, cin_i};
   assign sum_o  = full[W-1:0];
   assign cout_o = full[W];

endmodule

// File: verif/ncd_core_asserts.sv
// Checker for the nibble core decoder, bound to the top module's ports.
// Assumes one clock domain and the active-low asynchronous reset.
module ncd_core_asserts
   import ncd_pkg::*;
#(
   parameter int STACK_W = 3
) (
   // Clock and control
   input wire logic              clk_sys_i,
   input wire logic              rst_n_i,
   input wire logic              clk_en_i,
   input wire logic              instr_valid_i,
   input wire logic [NCD_IW-1:0] instr_i,
   input wire logic              busy_o,
   // Memory side
   input wire logic [3:0]        ram_rdata_i,
   input wire logic              ram_we_o,
   input wire logic [3:0]        ram_wdata_o,
   input wire logic [3:0]        file_sel_o,
   input wire logic [3:0]        digit_sel_o,
   input wire logic              rom_req_o,
   input wire logic [6:0]        rom_addr_o,
   input wire logic [NCD_IW-1:0] rom_data_i,
   // State
   input wire logic [3:0]        acc_o,
   input wire logic [3:0]        aux_o,
   input wire logic [2:0]        rom_addr_low_o,
   input wire logic              carry_flag_o,
   input wire logic              skip_pending_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   // =========================================================================
   // Helpers: an executed word, and sums computed from the rules
   logic       tk;
   logic [3:0] file_x;
   logic [4:0] imm_sum;
   logic [4:0] adc_sum;
   assign tk      = clk_en_i && instr_valid_i && !busy_o && !skip_pending_o;
   assign file_x  = file_sel_o ^ instr_i[3:0];
   assign imm_sum = {1'b0, acc_o} + {1'b0, instr_i[3:0]};
   assign adc_sum = {1'b0, acc_o} + {1'b0, ram_rdata_i} + {4'h0, carry_flag_o};

   // =========================================================================
   // Assertions
   a_inc_skip_zero: assert property (tk && instr_i == OP_DIGIT_INC |=>
      digit_sel_o == $past(digit_sel_o) + 4'h1 && skip_pending_o == (digit_sel_o == 4'h0))
      else $error("digit increment or its skip wrong");
   a_swap_dec_skip: assert property (tk && instr_i[9:4] == PFX_SWAP_DEC |-> ram_we_o && ram_wdata_o == acc_o ##1
      acc_o == $past(ram_rdata_i) && digit_sel_o == $past(digit_sel_o) - 4'h1 &&
      skip_pending_o == (digit_sel_o == 4'hf))
      else $error("swap with decrement wrong");
   a_load_ram_xor: assert property (tk && instr_i[9:4] == PFX_LOAD_ACC_RAM |=>
      acc_o == $past(ram_rdata_i) && file_sel_o == $past(file_x))
      else $error("load from memory wrong");
   a_store_ram_xor: assert property (tk && instr_i[9:4] == PFX_STORE_ACC_RAM |->
      ram_we_o && ram_wdata_o == acc_o ##1 file_sel_o == $past(file_x))
      else $error("store to memory wrong");
   a_add_carry_sum: assert property (tk && instr_i == OP_ADD_RAM_CARRY |=>
      {carry_flag_o, acc_o} == $past(adc_sum))
      else $error("add with carry wrong");
   a_add_imm_skip: assert property (tk && instr_i[9:4] == PFX_ADD_IMM |=>
      {!skip_pending_o, acc_o} == $past(imm_sum) && $stable(carry_flag_o))
      else $error("add immediate wrong");
   a_read_addr_low: assert property (tk && instr_i == OP_READ_RAL |=>
      acc_o == {1'b0, $past(rom_addr_low_o)})
      else $error("read of address low wrong");
   a_lookup_result: assert property (tk && instr_i[9:6] == PFX_ROM_LOOKUP |-> rom_req_o ##1 busy_o ##1
      {rom_addr_low_o, aux_o, acc_o} == {1'b0, $past(rom_data_i)})
      else $error("table lookup wrong");
   a_lookup_addr: assert property (rom_req_o |-> tk && instr_i[9:6] == PFX_ROM_LOOKUP &&
      rom_addr_o == {rom_addr_low_o, acc_o})
      else $error("lookup address wrong");
   a_skip_no_write: assert property ((tk && instr_i == OP_DIGIT_INC && digit_sel_o == 4'hf) ##1
      (clk_en_i && instr_valid_i && instr_i[9:4] == PFX_STORE_ACC_RAM) |-> !ram_we_o)
      else $error("skipped store wrote memory");

   // Main scenarios reached
   c_lookup: cover property (rom_req_o ##1 busy_o);
   c_skip: cover property (tk && instr_i == OP_DIGIT_INC && digit_sel_o == 4'hf);
   c_carry_out: cover property (tk && instr_i == OP_ADD_RAM_CARRY && adc_sum[4]);
endmodule

bind ncd_core ncd_core_asserts #(.STACK_W(STACK_W)) u_ncd_core_asserts (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .instr_valid_i(instr_valid_i),
   .instr_i(instr_i), .busy_o(busy_o), .ram_rdata_i(ram_rdata_i), .ram_we_o(ram_we_o),
   .ram_wdata_o(ram_wdata_o), .file_sel_o(file_sel_o), .digit_sel_o(digit_sel_o), .rom_req_o(rom_req_o),
   .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i), .acc_o(acc_o), .aux_o(aux_o),
   .rom_addr_low_o(rom_addr_low_o), .carry_flag_o(carry_flag_o), .skip_pending_o(skip_pending_o)
);

// File: verif/ncd_mem_model.sv
// Data memory and lookup table standing behind the nibble core decoder.
// Assumes the core clock; memory is read at the pointer with no delay.
module ncd_mem_model (
   // Clock
   input  wire logic       clk_sys_i,
   // Data memory
   input  wire logic [1:0] bank_sel_i,
   input  wire logic [3:0] file_sel_i,
   input  wire logic [3:0] digit_sel_i,
   input  wire logic       ram_we_i,
   input  wire logic [3:0] ram_wdata_i,
   output logic      [3:0] ram_rdata_o,
   // Lookup table
   input  wire logic       rom_req_i,
   input  wire logic [5:0] rom_page_i,
   input  wire logic [6:0] rom_addr_i,
   output logic      [9:0] rom_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] mem_q [0:1023];
   logic [9:0] addr;
   assign addr = {bank_sel_i, file_sel_i, digit_sel_i};
   assign ram_rdata_o = mem_q[addr];
   // Known contents: each nibble is its digit index xor a
   initial begin
      rom_data_o = 10'h000;
      for (int i = 0; i < 1024; i++) begin
         mem_q[i] = i[3:0] ^ 4'ha;
      end
   end
   // Writes land on the edge; the table word is good for one cycle only,
   // and is inverted each cycle otherwise, so that a read one cycle late sees wrong data
   always @(posedge clk_sys_i) begin
      if (ram_we_i) begin
         mem_q[addr] <= ram_wdata_i;
      end
      if (rom_req_i) begin
         rom_data_o <= {rom_page_i[2:0], ~rom_addr_i};
      end else begin
         rom_data_o <= ~rom_data_o;
      end
   end
endmodule

// File: verif/tb.sv
// Self-checking bench for the nibble core decoder with its memory model.
// Assumes words are offered on the falling edge and held until taken.
module tb
   import ncd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       clk_en_i = 1'b1;
   logic       instr_valid_i = 1'b0;
   logic [9:0] instr_i = 10'h000;
   logic [2:0] stack_depth_i = 3'h0;
   logic       busy_o, ram_we_o, rom_req_o, carry_flag_o, skip_pending_o;
   logic [3:0] ram_rdata_i, ram_wdata_o, file_sel_o, digit_sel_o, acc_o, aux_o;
   logic [1:0] bank_sel_o;
   logic [5:0] rom_page_o;
   logic [6:0] rom_addr_o;
   logic [9:0] rom_data_i;
   logic [7:0] wide_o;
   logic [2:0] rom_addr_low_o;
   int         n_fail = 0;
   int         samples_checked = 0;
   int         cyc = 0;

   // 200 MHz core clock
   always #2.5 clk_sys_i = ~clk_sys_i;

   ncd_core u_ncd_core (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .busy_o(busy_o), .ram_rdata_i(ram_rdata_i), .ram_we_o(ram_we_o),
      .ram_wdata_o(ram_wdata_o), .bank_sel_o(bank_sel_o), .file_sel_o(file_sel_o), .digit_sel_o(digit_sel_o),
      .rom_req_o(rom_req_o), .rom_page_o(rom_page_o), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
      .stack_depth_i(stack_depth_i), .acc_o(acc_o), .aux_o(aux_o), .wide_o(wide_o),
      .rom_addr_low_o(rom_addr_low_o), .carry_flag_o(carry_flag_o), .skip_pending_o(skip_pending_o)
   );
   ncd_mem_model u_ncd_mem_model (
      .clk_sys_i(clk_sys_i), .bank_sel_i(bank_sel_o), .file_sel_i(file_sel_o), .digit_sel_i(digit_sel_o),
      .ram_we_i(ram_we_o), .ram_wdata_i(ram_wdata_o), .ram_rdata_o(ram_rdata_i), .rom_req_i(rom_req_o),
      .rom_page_i(rom_page_o), .rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i)
   );

   // =========================================================================
   // Shared tasks
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Words go back to back; a busy cycle holds the last word in place
   task automatic seq(input logic [9:0] ws[$]);
      foreach (ws[k]) begin
         while (busy_o !== 1'b0) @(negedge clk_sys_i);
         instr_i = ws[k];
         instr_valid_i = 1'b1;
         @(negedge clk_sys_i);
      end
      instr_valid_i = 1'b0;
      @(negedge clk_sys_i);
   endtask
   task automatic test_done();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // =========================================================================
   // Scenarios
   task automatic t_runs();
      seq('{10'h312, 10'h345, 10'h075, 10'h079, 10'h00e});
      chk("file", file_sel_o, 8'h01);
      chk("digit", digit_sel_o, 8'h02);
      chk("acc", acc_o, 8'h05);
      chk("aux", aux_o, 8'h05);
      seq('{10'h2b3, 10'h2c3});
      chk("acc", acc_o, 8'h08);
      chk("file", file_sel_o, 8'h01);
      seq('{10'h2c0});
      chk("acc", acc_o, 8'h05);
   endtask
   task automatic t_swaps();
      seq('{10'h31f, 10'h073, 10'h2e1, 10'h01f});
      chk("acc", acc_o, 8'h05);
      chk("digit", digit_sel_o, 8'h00);
      chk("file", file_sel_o, 8'h00);
      seq('{10'h2f1, 10'h01f});
      chk("acc", acc_o, 8'h0a);
      chk("digit", digit_sel_o, 8'h0f);
      seq('{10'h2d0, 10'h2c0});
      chk("acc", acc_o, 8'h0a);
      chk("skip", skip_pending_o, 8'h00);
   endtask
   task automatic t_digits();
      seq('{10'h30e, 10'h013});
      chk("skip", skip_pending_o, 8'h00);
      seq('{10'h013, 10'h01f, 10'h017, 10'h01f});
      chk("digit", digit_sel_o, 8'h0f);
      chk("acc", acc_o, 8'h0a);
      seq('{10'h01c, 10'h017, 10'h01f});
      chk("acc", acc_o, 8'h0e);
      seq('{10'h30f, 10'h013, 10'h2b0, 10'h2c0});
      chk("acc", acc_o, 8'h05);
   endtask
   task automatic t_moves();
      stack_depth_i = 3'h5;
      seq('{10'h076, 10'h00e, 10'h079, 10'h01a, 10'h01e, 10'h02a});
      chk("wide", wide_o, 8'h69);
      chk("aux", aux_o, 8'h06);
      chk("acc", acc_o, 8'h09);
      seq('{10'h029, 10'h051});
      chk("addr_low", rom_addr_low_o, 8'h01);
      chk("acc", acc_o, 8'h01);
      seq('{10'h04a, 10'h053});
      chk("bank", bank_sel_o, 8'h02);
      chk("acc", acc_o, 8'h02);
      seq('{10'h3c0, 10'h052, 10'h00e, 10'h050, 10'h00c, 10'h048});
      chk("aux", aux_o, 8'h0c);
      chk("acc", acc_o, 8'h05);
      chk("digit", digit_sel_o, 8'h05);
   endtask
   task automatic t_arith();
      seq('{10'h07f, 10'h300, 10'h00b});
      chk("sum", {carry_flag_o, acc_o}, 8'h14);
      seq('{10'h00b});
      chk("sum", {carry_flag_o, acc_o}, 8'h0a);
      seq('{10'h007, 10'h00a});
      chk("sum", {carry_flag_o, acc_o}, 8'h1f);
      seq('{10'h063, 10'h01c});
      chk("sum", {carry_flag_o, acc_o}, 8'h1d);
      seq('{10'h061, 10'h01c});
      chk("acc", acc_o, 8'h0e);
      seq('{10'h018, 10'h019, 10'h01c});
      chk("sum", {carry_flag_o, acc_o}, 8'h1a);
      seq('{10'h05d, 10'h04c, 10'h2c0, 10'h020, 10'h01c, 10'h021, 10'h01c});
      chk("acc", acc_o, 8'h09);
   endtask
   task automatic t_lookup();
      seq('{10'h073, 10'h086, 10'h00e});
      chk("addr_low", rom_addr_low_o, 8'h03);
      chk("aux", aux_o, 8'h0c);
      chk("acc", acc_o, 8'h0c);
   endtask

   // Main sequence, after eight cycles of reset
   initial begin
      repeat (8) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      @(negedge clk_sys_i);
      t_runs();
      t_swaps();
      t_digits();
      t_moves();
      t_arith();
      t_lookup();
      test_done();
   end
   // Hang guard: the scenarios need well under a few hundred cycles
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail++;
         test_done();
      end
   end
endmodule
